// ===== sar_conv_pkg.sv
// constants for the sar converter conversion control block
`default_nettype none
package sar_conv_pkg;
    localparam int RESULT_W          = 14;
    localparam int CONV_CYCLES       = 16;
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int CONV_TIME_NS_X10  = 22;     // 2.2 us, in units of 0.1 us
    localparam int CONV_TIME_PS      = CONV_TIME_NS_X10 * 100000;
    localparam int CONV_TIME_CYC     = CONV_TIME_PS / CLK_PERIOD_PS;
    localparam int APERTURE_NS       = 15;
    localparam int APERTURE_CYC_RAW  = (APERTURE_NS * 1000) / CLK_PERIOD_PS;
    localparam int APERTURE_CYC      = (APERTURE_CYC_RAW < 1) ? 1
                                       : APERTURE_CYC_RAW;
    // internal oscillator divider: 16 ticks must fit the conversion time
    localparam int OSC_DIV_RAW       = (CONV_TIME_CYC - APERTURE_CYC)
                                       / CONV_CYCLES;
    localparam int OSC_DIV           = (OSC_DIV_RAW < 1) ? 1 : OSC_DIV_RAW;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 14'h0000;
endpackage : sar_conv_pkg
`default_nettype wire

// ===== sar_register.sv
// successive-approximation register stepped by conversion clock ticks
`timescale 1ns/1ps
`default_nettype none
module sar_register #(
    parameter int WIDTH = 14
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    // control
    input  wire logic             start_i,
    input  wire logic             tick_i,
    input  wire logic             cmp_i,
    // result
    output logic [WIDTH-1:0]      trial_o,
    output logic                  done_o
);
    logic [WIDTH-1:0] bit_mask;

    // binary search, msb first, one bit decided per tick
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            trial_o  <= '0;
            bit_mask <= '0;
            done_o   <= 1'b0;
        end
        else if (start_i)
        begin
            trial_o  <= {1'b1, {(WIDTH-1){1'b0}}};
            bit_mask <= {1'b1, {(WIDTH-1){1'b0}}};
            done_o   <= 1'b0;
        end
        else if (tick_i && bit_mask != '0)
        begin
            if (!cmp_i)
                trial_o <= (trial_o & ~bit_mask) | (bit_mask >> 1);
            else
                trial_o <= trial_o | (bit_mask >> 1);
            bit_mask <= bit_mask >> 1;
            done_o   <= (bit_mask == {{(WIDTH-1){1'b0}}, 1'b1});
        end
        else
            done_o <= 1'b0;
    end
endmodule : sar_register
`default_nettype wire

// ===== sar_adc_conversion_control.sv
// conversion control and parallel read interface of a 14-bit sar converter
// Summary of operation
// - a rising sample_trigger edge holds the input and starts a conversion.
// - the busy flag rises at the trigger edge and stays high all conversion.
// - external_conv_clock high at the trigger picks it, else the oscillator.
// - at conversion end busy falls and track/hold tracks again at once.
// - after busy falls the host reads the 14-bit result, select and read low.
// - with the oscillator a conversion finishes within 2.2 us of the trigger.
// - hold is entered an aperture delay of 15 ns after the trigger edge.
// - each conversion takes sixteen cycles of the selected conversion clock.
// - outputs drive only while read and select are both low; bit 13 is msb.
// - busy falls at conversion end whatever the sample_trigger level.
// - bipolar versions output two's complement, unipolar straight binary.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control #(
    parameter int  RESULT_W = sar_conv_pkg::RESULT_W,
    parameter bit  BIPOLAR  = 1'b1
) (
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    // conversion control pins
    input  wire logic                sample_trigger_i,
    input  wire logic                external_conv_clock_i,
    output logic                     busy_o,
    // analog front end: comparator and track/hold
    input  wire logic                comparator_i,
    output logic [RESULT_W-1:0]      dac_trial_o,
    output logic                     hold_o,
    // parallel read bus
    input  wire logic                cs_n_i,
    input  wire logic                rd_n_i,
    output logic [RESULT_W-1:0]      result_bus_o,
    output logic [RESULT_W-1:0]      result_bus_oe_o
);
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0001,
        ST_APERTURE = 4'b0010,
        ST_CONVERT  = 4'b0100,
        ST_FINISH   = 4'b1000
    } state_t;

    state_t           state;
    logic [1:0]       trig_sync;
    logic [1:0]       eclk_sync;
    logic [1:0]       cs_sync;
    logic [1:0]       rd_sync;
    logic             trig_d;
    logic             eclk_d;
    logic             use_ext;
    logic [7:0]       wait_cnt;
    logic [7:0]       osc_cnt;
    logic             tick;
    logic             trig_rise;
    logic             sar_start;
    logic             sar_done;
    logic [4:0]       tick_cnt;
    logic [4:0]       ticks_seen;
    logic             conv_last;
    logic [RESULT_W-1:0] sar_trial;
    logic [RESULT_W-1:0] result;

    // two-stage synchronisers for trigger, clock select, select and read pins; comparator is not synchronised
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            trig_sync <= 2'h0;
            eclk_sync <= 2'h0;
            cs_sync   <= 2'h3;
            rd_sync   <= 2'h3;
        end
        else
        begin
            trig_sync <= {trig_sync[0], sample_trigger_i};
            eclk_sync <= {eclk_sync[0], external_conv_clock_i};
            cs_sync   <= {cs_sync[0], cs_n_i};
            rd_sync   <= {rd_sync[0], rd_n_i};
        end
    end

    // edge history of the synchronised levels
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            trig_d <= 1'b0;
            eclk_d <= 1'b0;
        end
        else
        begin
            trig_d <= trig_sync[1];
            eclk_d <= eclk_sync[1];
        end
    end

    assign trig_rise = trig_sync[1] && !trig_d;
    assign sar_start = (state == ST_APERTURE) && (wait_cnt == 8'h00);
    assign conv_last = tick && (tick_cnt == 5'(sar_conv_pkg::CONV_CYCLES - 1));

    // conversion clock tick: oscillator divider or external rising edge
    always_comb
    begin
        if (state != ST_CONVERT)
            tick = 1'b0;
        else if (use_ext)
            tick = eclk_sync[1] && !eclk_d;
        else
            tick = (osc_cnt == 8'h00);
    end

    // internal oscillator divider, restarted at each conversion
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || state != ST_CONVERT)
            osc_cnt <= 8'(sar_conv_pkg::OSC_DIV - 1);
        else if (osc_cnt == 8'h00)
            osc_cnt <= 8'(sar_conv_pkg::OSC_DIV - 1);
        else
            osc_cnt <= osc_cnt - 8'h01;
    end

    // conversion clock cycles counted within the current conversion
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || state != ST_CONVERT)
            tick_cnt <= 5'h00;
        else if (tick)
            tick_cnt <= tick_cnt + 5'h01;
    end

    // conversion sequencer
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            state    <= ST_IDLE;
            use_ext  <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (trig_rise)
                    begin
                        use_ext  <= eclk_sync[1];
                        wait_cnt <= 8'(sar_conv_pkg::APERTURE_CYC - 1);
                        state    <= ST_APERTURE;
                    end
                end
                ST_APERTURE:
                begin
                    if (wait_cnt == 8'h00)
                        state <= ST_CONVERT;
                    else
                        wait_cnt <= wait_cnt - 8'h01;
                end
                ST_CONVERT:
                begin
                    if (conv_last)   // all sixteen cycles used
                        state <= ST_FINISH;
                end
                ST_FINISH:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // busy and hold outputs follow the sequencer
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            busy_o <= 1'b0;
            hold_o <= 1'b0;
        end
        else
        begin
            if (state == ST_IDLE && trig_rise)
                busy_o <= 1'b1;
            else if (state == ST_FINISH)
                busy_o <= 1'b0;
            if (sar_start)
                hold_o <= 1'b1;
            else if (state == ST_FINISH)
                hold_o <= 1'b0;
        end
    end

    sar_register #(
        .WIDTH     (RESULT_W)
    ) u_sar (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (sar_start),
        .tick_i    (tick),
        .cmp_i     (comparator_i),
        .trial_o   (sar_trial),
        .done_o    (sar_done)
    );

    // trial word to the dac, result latched at conversion end
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            dac_trial_o <= sar_conv_pkg::RESULT_RESET;
            result      <= sar_conv_pkg::RESULT_RESET;
        end
        else
        begin
            dac_trial_o <= sar_trial;
            if (conv_last)   // flip msb for two's complement
                result <= BIPOLAR ? (sar_trial ^ {1'b1, {(RESULT_W-1){1'b0}}})
                                  : sar_trial;
        end
    end

    // parallel read bus, driven only with select and read low
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            result_bus_o    <= sar_conv_pkg::RESULT_RESET;
            result_bus_oe_o <= '0;
        end
        else
        begin
            result_bus_o    <= result;
            result_bus_oe_o <= {RESULT_W{!cs_sync[1] && !rd_sync[1]}};
        end
    end

    // checks
    sequence s_trigger;
        state == ST_IDLE && trig_rise;
    endsequence

    // three clear cycles of aperture, then hold
    sequence s_aperture;
        !hold_o [*3] ##1 hold_o;
    endsequence

    // ticks seen since the search began, for the length check
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || sar_start)
            ticks_seen <= 5'h00;
        else if (tick)
            ticks_seen <= ticks_seen + 5'h01;
    end

    AST_BUSY_RISE: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        s_trigger |=> busy_o) else $error("busy not raised");
    AST_HOLD_APERTURE: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        s_trigger |=> s_aperture) else $error("aperture wrong");
    AST_BUSY_STAYS: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        state == ST_CONVERT |-> busy_o) else $error("busy dropped");
    AST_END_TOGETHER: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        $fell(busy_o) |-> $fell(hold_o))
        else $error("hold not released");
    AST_INT_TIME: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (s_trigger and !eclk_sync[1]) |-> ##[1:440] !busy_o)
        else $error("conversion too slow");
    AST_EXT_SELECT: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        s_trigger |=> use_ext == $past(eclk_sync[1]))
        else $error("clock select wrong");
    AST_OE_GATE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        result_bus_oe_o[0] |-> $past(!cs_sync[1] && !rd_sync[1]))
        else $error("bus enabled wrongly");
    AST_TICKS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(busy_o) |-> ticks_seen == 5'(sar_conv_pkg::CONV_CYCLES))
        else $error("tick count wrong");
    AST_SAR_DONE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        sar_done |-> tick_cnt == 5'(RESULT_W))
        else $error("search ended off count");
endmodule : sar_adc_conversion_control
`default_nettype wire

// ===== analog_core_model.sv
// behavioural track/hold and comparator facing the conversion block
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
    // clock
    input  wire logic                            sys_clk_i,
    // track/hold control and trial word from the block
    input  wire logic                            hold_i,
    input  wire logic [sar_conv_pkg::RESULT_W-1:0] dac_trial_i,
    // analog input level, as an offset binary code
    input  wire logic [sar_conv_pkg::RESULT_W-1:0] level_i,
    // comparator decision
    output logic                                 comparator_o
);
    logic [sar_conv_pkg::RESULT_W-1:0] held;

    // track while hold is low, freeze while hold is high
    always_ff @(posedge sys_clk_i)
        if (!hold_i)
            held <= level_i;

    // one when the held input reaches the trial word
    assign comparator_o = (held >= dac_trial_i);
endmodule : analog_core_model
`default_nettype wire

// ===== tb_top.sv
// self-checking testbench for the sar conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int W = sar_conv_pkg::RESULT_W;
    logic         sys_clk   = 1'b0;
    logic         sys_rst   = 1'b1;
    logic         trig      = 1'b0;
    logic         ext_clk   = 1'b0;
    logic         cs_n      = 1'b1;
    logic         rd_n      = 1'b1;
    logic [W-1:0] level     = 14'h0000;
    logic         cmp;
    logic         busy;
    logic         hold;
    logic [W-1:0] trial;
    logic [W-1:0] bus;
    logic [W-1:0] oe;
    logic         cmp_u;
    logic         hold_u;
    logic [W-1:0] trial_u;
    logic [W-1:0] bus_u;
    logic [W-1:0] oe_u;
    int           n_fail    = 0;
    int           cmp_count = 0;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    // block under test and the analog core beside it
    sar_adc_conversion_control #(.BIPOLAR(1'b1)) dut (.sys_clk_i(sys_clk),
        .sys_rst_i(sys_rst), .sample_trigger_i(trig),
        .external_conv_clock_i(ext_clk), .busy_o(busy),
        .comparator_i(cmp), .dac_trial_o(trial), .hold_o(hold),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .result_bus_o(bus),
        .result_bus_oe_o(oe));
    analog_core_model core (.sys_clk_i(sys_clk), .hold_i(hold),
        .dac_trial_i(trial), .level_i(level), .comparator_o(cmp));

    // unipolar twin, straight binary output
    sar_adc_conversion_control #(.BIPOLAR(1'b0)) dut_u (.sys_clk_i(sys_clk),
        .sys_rst_i(sys_rst), .sample_trigger_i(trig),
        .external_conv_clock_i(ext_clk), .busy_o(),
        .comparator_i(cmp_u), .dac_trial_o(trial_u), .hold_o(hold_u),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .result_bus_o(bus_u),
        .result_bus_oe_o(oe_u));
    analog_core_model core_u (.sys_clk_i(sys_clk), .hold_i(hold_u),
        .dac_trial_i(trial_u), .level_i(level), .comparator_o(cmp_u));

    task automatic check(input logic [W-1:0] seen, input logic [W-1:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // a wait that used up its bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim)
        begin
            n_fail++;
            summarize();
        end
    endtask : bound

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // select alone, then select with read, then release
    task automatic read_res(input logic [W-1:0] want);
        int n;
        n = 0;
        cs_n = 1'b0;
        cyc(5);
        check(oe, 14'h0000);
        rd_n = 1'b0;
        while (oe === 14'h0000 && n < 8)
        begin
            cyc(1);
            n++;
        end
        bound(n, 8);
        check(oe, 14'h3FFF);
        check(bus, want);
        check(oe_u, 14'h3FFF);
        check(bus_u, want ^ 14'h2000);
        cs_n = 1'b1;
        rd_n = 1'b1;
        cyc(5);
        check(oe, 14'h0000);
    endtask : read_res

    // one conversion; ext picks the outside clock, again re-triggers
    task automatic convert(input logic [W-1:0] v, input bit ext,
                           input bit again);
        int   n;
        int   nh;
        logic was_hold;
        logic in_time;
        nh = 0;
        level = v;
        ext_clk = ext;
        cyc(2);
        check({13'h0000, busy}, 14'h0000);
        trig = 1'b1;
        cyc(6);
        check({13'h0000, busy}, 14'h0001);
        trig = 1'b0;
        while (hold !== 1'b1 && nh < 8)
        begin
            cyc(1);
            nh++;
        end
        bound(nh, 8);
        check({13'h0000, hold}, 14'h0001);
        if (ext)
        begin
            cyc(14);
            repeat (15)
            begin
                ext_clk = 1'b0;
                cyc(4);
                ext_clk = 1'b1;
                cyc(4);
            end
            cyc(4);
            check({13'h0000, busy}, 14'h0001);
            ext_clk = 1'b0;
            cyc(4);
            ext_clk = 1'b1;
        end
        n = 0;
        was_hold = hold;
        while (busy === 1'b1 && n < 460)
        begin
            trig = again && n >= 150 && n < 156;
            was_hold = hold;
            cyc(1);
            n++;
        end
        bound(n, 460);
        in_time = ext ? (n <= 12)
                      : (6 + nh + n <= sar_conv_pkg::CONV_TIME_CYC);
        check({13'h0000, in_time}, 14'h0001);
        check({12'h000, was_hold, hold}, 14'h0002);
        trig = 1'b0;
        ext_clk = 1'b0;
        read_res(v ^ 14'h2000);
        cyc(80);
    endtask : convert

    // reset, then boundary codes in both clock modes
    initial
    begin
        cyc(8);
        check({12'h000, busy, hold}, 14'h0000);
        check(oe, 14'h0000);
        sys_rst = 1'b0;
        cyc(2);
        convert(14'h0000, 1'b0, 1'b0);
        convert(14'h3FFF, 1'b0, 1'b1);
        convert(14'h2000, 1'b0, 1'b0);
        convert(14'h1FFF, 1'b1, 1'b0);
        convert(14'h2AAA, 1'b1, 1'b0);
        convert(14'h1555, 1'b0, 1'b0);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
